// ==== rtl/pmx_consts.svh ====
// reset values and widths shared by the shared-pin selection logic
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// width of the strapped operating mode value
`define PMX_MODE_W        3
// operating mode shown until the straps have been taken
`define PMX_MODE_RST      3'h0
// pad output level after reset
`define PMX_PAD_OUT_RST   1'b0
// pad output enable after reset: released
`define PMX_PAD_OE_N_RST  1'b1
// level seen by the i2c controller while its pins are not selected: idle bus
`define PMX_I2C_IDLE      1'b1
// dma request and stop seen by the dma controller while not selected
`define PMX_DMA_IDLE      1'b0
// port input value after reset
`define PMX_PORT_IN_RST   1'b0
// least and greatest supported number of external dma channels
`define PMX_MIN_CH        1
`define PMX_MAX_CH        8

`endif

// ==== rtl/pmx_pkg.sv ====
// types carried between the pin selection top and its per-channel logic
package pmx_pkg;

  // per-channel function selections
  typedef struct packed {
    logic req_sel;      // external request chosen as dma start source
    logic ack_out_en;   // acknowledge output setting
    logic end_out_en;   // transfer-end output selection
    logic stop_in_en;   // transfer-stop input selection
  } pmx_chan_cfg_s;

  // the three pins of one dma channel; ch0 sits on port_b_bit0..2,
  // ch1 on port_b_bit3..5, ch2 on port_g_bit0..2
  typedef struct packed {
    logic req;
    logic ack;
    logic end_stop;
  } pmx_chan_pins_s;

  // the two pins shared with the two-wire bus: data, then clock
  typedef struct packed {
    logic port_h_bit6;
    logic port_h_bit7;
  } pmx_i2c_pins_s;

endpackage : pmx_pkg

// ==== rtl/pmx_dma_chan.sv ====
// function selection of the three shared pins of one external dma channel
`timescale 1ns/1ps
`include "pmx_consts.svh"

module pmx_dma_chan (
  // selections
  input  wire pmx_pkg::pmx_chan_cfg_s  i_cfg,
  // dma controller side
  input  wire logic                    i_dma_request_ack,
  input  wire logic                    i_dma_transfer_end_out,
  output logic                         o_dma_ext_request,
  output logic                         o_dma_transfer_stop_in,
  // general-purpose port side
  input  wire pmx_pkg::pmx_chan_pins_s i_port_out,
  input  wire pmx_pkg::pmx_chan_pins_s i_port_dir,
  output pmx_pkg::pmx_chan_pins_s      o_port_in,
  // pad side
  input  wire pmx_pkg::pmx_chan_pins_s i_pad_in,
  output pmx_pkg::pmx_chan_pins_s      o_pad_out,
  output pmx_pkg::pmx_chan_pins_s      o_pad_oe_n
);
  import pmx_pkg::*;

  always_comb begin
    // port input always reads the pad, so software can watch a live function
    o_port_in = i_pad_in;

    // request pin: only a port bit set to output may drive it, and only on purpose
    o_dma_ext_request   = i_cfg.req_sel ? i_pad_in.req : `PMX_DMA_IDLE;
    o_pad_out.req       = i_port_out.req;
    o_pad_oe_n.req      = ~i_port_dir.req;

    // acknowledge pin
    if (i_cfg.ack_out_en) begin
      o_pad_out.ack  = i_dma_request_ack;
      o_pad_oe_n.ack = 1'b0;
    end else begin
      o_pad_out.ack  = i_port_out.ack;
      o_pad_oe_n.ack = ~i_port_dir.ack;
    end

    // transfer-end / transfer-stop pin; with both selected the stop input reads
    // back the end output, which is the user's own choice
    o_dma_transfer_stop_in = i_cfg.stop_in_en ? i_pad_in.end_stop : `PMX_DMA_IDLE;
    if (i_cfg.end_out_en) begin
      o_pad_out.end_stop  = i_dma_transfer_end_out;
      o_pad_oe_n.end_stop = 1'b0;
    end else if (i_cfg.stop_in_en) begin
      o_pad_out.end_stop  = `PMX_PAD_OUT_RST;
      o_pad_oe_n.end_stop = 1'b1;
    end else begin
      o_pad_out.end_stop  = i_port_out.end_stop;
      o_pad_oe_n.end_stop = ~i_port_dir.end_stop;
    end
  end

endmodule : pmx_dma_chan

// ==== rtl/pmx_pin_mux.sv ====
// shared-pin function selection for the two-wire bus and external dma channels
`timescale 1ns/1ps
`include "pmx_consts.svh"

module pmx_pin_mux #(
  parameter int NUM_CH = 3
) (
  // clock and reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_sys_rst,
  // static selections
  input  wire logic                                 i_i2c_enable,
  input  wire pmx_pkg::pmx_chan_cfg_s  [NUM_CH-1:0] i_chan_cfg,
  input  wire logic [`PMX_MODE_W-1:0]               i_operating_mode_pins,
  // two-wire bus controller
  input  wire logic                                 i_i2c_sda_drive_low,
  input  wire logic                                 i_i2c_scl_drive_low,
  output logic                                      o_i2c_sda_in,
  output logic                                      o_i2c_scl_in,
  // dma controller
  input  wire logic [NUM_CH-1:0]                    i_dma_request_ack,
  input  wire logic [NUM_CH-1:0]                    i_dma_transfer_end_out,
  output logic [NUM_CH-1:0]                         o_dma_ext_request,
  output logic [NUM_CH-1:0]                         o_dma_transfer_stop_in,
  // general-purpose port
  input  wire pmx_pkg::pmx_i2c_pins_s               i_i2c_port_out,
  input  wire pmx_pkg::pmx_i2c_pins_s               i_i2c_port_dir,
  output pmx_pkg::pmx_i2c_pins_s                    o_i2c_port_in,
  input  wire pmx_pkg::pmx_chan_pins_s [NUM_CH-1:0] i_chan_port_out,
  input  wire pmx_pkg::pmx_chan_pins_s [NUM_CH-1:0] i_chan_port_dir,
  output pmx_pkg::pmx_chan_pins_s      [NUM_CH-1:0] o_chan_port_in,
  // pads
  input  wire pmx_pkg::pmx_i2c_pins_s               i_i2c_pad_in,
  output pmx_pkg::pmx_i2c_pins_s                    o_i2c_pad_out,
  output pmx_pkg::pmx_i2c_pins_s                    o_i2c_pad_oe_n,
  input  wire pmx_pkg::pmx_chan_pins_s [NUM_CH-1:0] i_chan_pad_in,
  output pmx_pkg::pmx_chan_pins_s      [NUM_CH-1:0] o_chan_pad_out,
  output pmx_pkg::pmx_chan_pins_s      [NUM_CH-1:0] o_chan_pad_oe_n,
  // operating mode
  output logic [`PMX_MODE_W-1:0]                    o_operating_mode,
  output logic                                      o_mode_valid
);
  import pmx_pkg::*;

  // refused while the design is built, not first noticed at run time
  if (NUM_CH < `PMX_MIN_CH || NUM_CH > `PMX_MAX_CH) begin : g_bad_num_ch
    $error("pmx_pin_mux: NUM_CH out of range");
  end

  // ---- two-wire bus pins
  pmx_i2c_pins_s next_i2c_pad_out;
  pmx_i2c_pins_s next_i2c_pad_oe_n;
  pmx_i2c_pins_s next_i2c_port_in;
  logic          next_i2c_sda_in;
  logic          next_i2c_scl_in;

  always_comb begin
    next_i2c_port_in = i_i2c_pad_in;
    if (i_i2c_enable) begin
      // port value and direction ignored so the port cannot fight the bus
      next_i2c_pad_out.port_h_bit6  = 1'b0;
      next_i2c_pad_out.port_h_bit7  = 1'b0;
      // open drain: the only level ever driven is low
      next_i2c_pad_oe_n.port_h_bit6 = ~i_i2c_sda_drive_low;
      next_i2c_pad_oe_n.port_h_bit7 = ~i_i2c_scl_drive_low;
      next_i2c_sda_in               = i_i2c_pad_in.port_h_bit6;
      next_i2c_scl_in               = i_i2c_pad_in.port_h_bit7;
    end else begin
      next_i2c_pad_out  = i_i2c_port_out;
      next_i2c_pad_oe_n = ~i_i2c_port_dir;
      // controller sees an idle bus rather than port traffic
      next_i2c_sda_in   = `PMX_I2C_IDLE;
      next_i2c_scl_in   = `PMX_I2C_IDLE;
    end
    if (i_sys_rst) begin
      next_i2c_pad_out  = {2{`PMX_PAD_OUT_RST}};
      next_i2c_pad_oe_n = {2{`PMX_PAD_OE_N_RST}};
      next_i2c_port_in  = {2{`PMX_PORT_IN_RST}};
      next_i2c_sda_in   = `PMX_I2C_IDLE;
      next_i2c_scl_in   = `PMX_I2C_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    o_i2c_pad_out  <= next_i2c_pad_out;
    o_i2c_pad_oe_n <= next_i2c_pad_oe_n;
    o_i2c_port_in  <= next_i2c_port_in;
    o_i2c_sda_in   <= next_i2c_sda_in;
    o_i2c_scl_in   <= next_i2c_scl_in;
  end

  // ---- dma channel pins
  // a registered stage costs one cycle on handshakes but keeps pads glitch free
  logic           [NUM_CH-1:0] chan_req;
  logic           [NUM_CH-1:0] chan_stop;
  pmx_chan_pins_s [NUM_CH-1:0] chan_port_in;
  pmx_chan_pins_s [NUM_CH-1:0] chan_pad_out;
  pmx_chan_pins_s [NUM_CH-1:0] chan_pad_oe_n;
  logic           [NUM_CH-1:0] next_dma_ext_request;
  logic           [NUM_CH-1:0] next_dma_transfer_stop_in;
  pmx_chan_pins_s [NUM_CH-1:0] next_chan_port_in;
  pmx_chan_pins_s [NUM_CH-1:0] next_chan_pad_out;
  pmx_chan_pins_s [NUM_CH-1:0] next_chan_pad_oe_n;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      pmx_dma_chan u_chan (
        .i_cfg                  (i_chan_cfg[g]),
        .i_dma_request_ack      (i_dma_request_ack[g]),
        .i_dma_transfer_end_out (i_dma_transfer_end_out[g]),
        .o_dma_ext_request      (chan_req[g]),
        .o_dma_transfer_stop_in (chan_stop[g]),
        .i_port_out             (i_chan_port_out[g]),
        .i_port_dir             (i_chan_port_dir[g]),
        .o_port_in              (chan_port_in[g]),
        .i_pad_in               (i_chan_pad_in[g]),
        .o_pad_out              (chan_pad_out[g]),
        .o_pad_oe_n             (chan_pad_oe_n[g])
      );

      property p_req_sample;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |->
          o_dma_ext_request[g] == ($past(i_chan_cfg[g].req_sel) & $past(i_chan_pad_in[g].req));
      endproperty
      a_req_sample: assert property (p_req_sample)
        else $error("request not sampled as selected");

      property p_req_no_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && $past(i_chan_cfg[g].req_sel) && !$past(i_chan_port_dir[g].req)
          |-> o_chan_pad_oe_n[g].req;
      endproperty
      a_req_no_drive: assert property (p_req_no_drive)
        else $error("selected request pin driven");

      property p_ack_out;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && $past(i_chan_cfg[g].ack_out_en) |->
          !o_chan_pad_oe_n[g].ack && o_chan_pad_out[g].ack == $past(i_dma_request_ack[g]);
      endproperty
      a_ack_out: assert property (p_ack_out)
        else $error("acknowledge not driven");

      property p_ack_port;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && !$past(i_chan_cfg[g].ack_out_en) |->
          o_chan_pad_oe_n[g].ack == !$past(i_chan_port_dir[g].ack) &&
          o_chan_pad_out[g].ack == $past(i_chan_port_out[g].ack);
      endproperty
      a_ack_port: assert property (p_ack_port)
        else $error("acknowledge pin not a port bit");

      property p_end_out;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && $past(i_chan_cfg[g].end_out_en) |->
          !o_chan_pad_oe_n[g].end_stop &&
          o_chan_pad_out[g].end_stop == $past(i_dma_transfer_end_out[g]);
      endproperty
      a_end_out: assert property (p_end_out)
        else $error("transfer end not driven");

      property p_stop_in;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |-> o_dma_transfer_stop_in[g] ==
          ($past(i_chan_cfg[g].stop_in_en) & $past(i_chan_pad_in[g].end_stop));
      endproperty
      a_stop_in: assert property (p_stop_in)
        else $error("transfer stop gating wrong");

      property p_stop_released;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && $past(i_chan_cfg[g].stop_in_en) && !$past(i_chan_cfg[g].end_out_en)
          |-> o_chan_pad_oe_n[g].end_stop;
      endproperty
      a_stop_released: assert property (p_stop_released)
        else $error("stop input pin driven");

      property p_end_stop_port;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && !$past(i_chan_cfg[g].end_out_en) &&
          !$past(i_chan_cfg[g].stop_in_en) |->
          o_chan_pad_oe_n[g].end_stop == !$past(i_chan_port_dir[g].end_stop) &&
          o_chan_pad_out[g].end_stop == $past(i_chan_port_out[g].end_stop);
      endproperty
      a_end_stop_port: assert property (p_end_stop_port)
        else $error("end/stop pin not a port bit");

      c_ack_pulse: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_chan_pad_out[g].ack) && !o_chan_pad_oe_n[g].ack);
      c_stop_seen: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_dma_transfer_stop_in[g]));
    end
  endgenerate

  always_comb begin
    next_dma_ext_request      = chan_req;
    next_dma_transfer_stop_in = chan_stop;
    next_chan_port_in         = chan_port_in;
    next_chan_pad_out         = chan_pad_out;
    next_chan_pad_oe_n        = chan_pad_oe_n;
    if (i_sys_rst) begin
      next_dma_ext_request      = {NUM_CH{`PMX_DMA_IDLE}};
      next_dma_transfer_stop_in = {NUM_CH{`PMX_DMA_IDLE}};
      next_chan_port_in         = {(3*NUM_CH){`PMX_PORT_IN_RST}};
      next_chan_pad_out         = {(3*NUM_CH){`PMX_PAD_OUT_RST}};
      next_chan_pad_oe_n        = {(3*NUM_CH){`PMX_PAD_OE_N_RST}};
    end
  end

  always_ff @(posedge i_clk) begin
    o_dma_ext_request      <= next_dma_ext_request;
    o_dma_transfer_stop_in <= next_dma_transfer_stop_in;
    o_chan_port_in         <= next_chan_port_in;
    o_chan_pad_out         <= next_chan_pad_out;
    o_chan_pad_oe_n        <= next_chan_pad_oe_n;
  end

  // ---- operating mode straps
  // taken once, on the first edge after reset release; straps are static, so
  // later movement on the pins is deliberately ignored until the next reset
  logic [`PMX_MODE_W-1:0] next_operating_mode;
  logic                   next_mode_valid;

  always_comb begin
    if (i_sys_rst) begin
      next_operating_mode = `PMX_MODE_RST;
      next_mode_valid     = 1'b0;
    end else if (o_mode_valid) begin
      next_operating_mode = o_operating_mode;
      next_mode_valid     = 1'b1;
    end else begin
      next_operating_mode = i_operating_mode_pins;
      next_mode_valid     = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    o_operating_mode <= next_operating_mode;
    o_mode_valid     <= next_mode_valid;
  end

  // ---- checks on the bus pins and the mode
  property p_i2c_port;
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) && !$past(i_i2c_enable) |->
      o_i2c_pad_out == $past(i_i2c_port_out) && o_i2c_pad_oe_n == ~$past(i_i2c_port_dir) &&
      o_i2c_sda_in && o_i2c_scl_in;
  endproperty
  a_i2c_port: assert property (p_i2c_port)
    else $error("bus pins not port bits while bus off");

  property p_i2c_route;
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) && $past(i_i2c_enable) |->
      o_i2c_sda_in == $past(i_i2c_pad_in.port_h_bit6) &&
      o_i2c_scl_in == $past(i_i2c_pad_in.port_h_bit7);
  endproperty
  a_i2c_route: assert property (p_i2c_route)
    else $error("bus input not routed");

  property p_i2c_port_off;
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) && $past(i_i2c_enable) && !$past(i_i2c_sda_drive_low) &&
      !$past(i_i2c_scl_drive_low) |-> o_i2c_pad_oe_n == 2'h3;
  endproperty
  a_i2c_port_off: assert property (p_i2c_port_off)
    else $error("port drives a bus pin");

  property p_i2c_open_drain;
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) && $past(i_i2c_enable) |->
      o_i2c_pad_out == 2'h0 &&
      o_i2c_pad_oe_n.port_h_bit6 == !$past(i_i2c_sda_drive_low) &&
      o_i2c_pad_oe_n.port_h_bit7 == !$past(i_i2c_scl_drive_low);
  endproperty
  a_i2c_open_drain: assert property (p_i2c_open_drain)
    else $error("bus pin not open drain");

  property p_mode_take;
    @(posedge i_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |=> o_mode_valid && o_operating_mode == $past(i_operating_mode_pins);
  endproperty
  a_mode_take: assert property (p_mode_take)
    else $error("mode not taken from straps");

  property p_mode_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_mode_valid |=> o_mode_valid && $stable(o_operating_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed after capture");

  c_i2c_low: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(i_i2c_enable) ##1 !o_i2c_pad_oe_n.port_h_bit6);
  c_mode_set: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_mode_valid));

endmodule : pmx_pin_mux

// ==== test/pmx_far_side.sv ====
// far-side model: two-wire bus devices on a pulled-up bus and dma requesters
`timescale 1ns/1ps

module pmx_far_side (
  // design pads
  input  wire logic       i_clk,
  input  wire logic [8:0] i_chan_out,
  input  wire logic [8:0] i_chan_oe_n,
  input  wire logic [1:0] i_i2c_out,
  input  wire logic [1:0] i_i2c_oe_n,
  // bench commands
  input  wire logic [8:0] i_drv_en,
  input  wire logic [8:0] i_drv_val,
  input  wire logic [1:0] i_i2c_pull_low,
  // pad levels
  output logic      [8:0] o_chan_pad,
  output logic      [1:0] o_i2c_pad
);
  logic [8:0] last = '0;

  // pull-up bus: a device pulling low wins even against a port driving high
  always_comb begin
    o_i2c_pad = ~i_i2c_pull_low & (i_i2c_oe_n | i_i2c_out);
    for (int b = 0; b < 9; b++) begin
      if (!i_chan_oe_n[b]) begin
        o_chan_pad[b] = i_chan_out[b];
      end else if (i_drv_en[b]) begin
        o_chan_pad[b] = i_drv_val[b];
      end else begin
        // undriven line without pull: never repeat the old level
        o_chan_pad[b] = ~last[b];
      end
    end
  end

  always @(posedge i_clk) begin
    last <= o_chan_pad;
  end
endmodule : pmx_far_side

// ==== test/tb_pmx_pin_mux.sv ====
// self-checking bench for the shared-pin selection top
`timescale 1ns/1ps

module tb_pmx_pin_mux;
  import pmx_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst, i2c_en, sda_low, scl_low, sda_in, scl_in, mode_ok;
  logic           [2:0] straps, ack, eop, req_o, stop_o, mode_o;
  logic           [8:0] drv_en, drv_val;
  logic           [1:0] pull_low;
  pmx_chan_cfg_s  [2:0] cfg;
  pmx_i2c_pins_s        i2c_po, i2c_pd, i2c_pi, i2c_pad, i2c_out, i2c_oe;
  pmx_chan_pins_s [2:0] ch_po, ch_pd, ch_pi, ch_pad, ch_out, ch_oe;
  int                   n_mismatch = 0;
  int                   tests_run = 0;
  int                   cyc = 0;

  always #12.5 clk = ~clk;

  pmx_pin_mux #(.NUM_CH(3)) u_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_i2c_enable(i2c_en), .i_chan_cfg(cfg),
    .i_operating_mode_pins(straps), .i_i2c_sda_drive_low(sda_low),
    .i_i2c_scl_drive_low(scl_low), .o_i2c_sda_in(sda_in), .o_i2c_scl_in(scl_in),
    .i_dma_request_ack(ack), .i_dma_transfer_end_out(eop), .o_dma_ext_request(req_o),
    .o_dma_transfer_stop_in(stop_o), .i_i2c_port_out(i2c_po), .i_i2c_port_dir(i2c_pd),
    .o_i2c_port_in(i2c_pi), .i_chan_port_out(ch_po), .i_chan_port_dir(ch_pd),
    .o_chan_port_in(ch_pi), .i_i2c_pad_in(i2c_pad), .o_i2c_pad_out(i2c_out),
    .o_i2c_pad_oe_n(i2c_oe), .i_chan_pad_in(ch_pad), .o_chan_pad_out(ch_out),
    .o_chan_pad_oe_n(ch_oe), .o_operating_mode(mode_o), .o_mode_valid(mode_ok)
  );

  pmx_far_side u_far (
    .i_clk(clk), .i_chan_out(ch_out), .i_chan_oe_n(ch_oe), .i_i2c_out(i2c_out),
    .i_i2c_oe_n(i2c_oe), .i_drv_en(drv_en), .i_drv_val(drv_val),
    .i_i2c_pull_low(pull_low), .o_chan_pad(ch_pad), .o_i2c_pad(i2c_pad)
  );

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one cycle to register, one more for anything looped through the pads
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic tally_and_finish;
    $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic t_mode;
    chk(mode_o, 3'h5);
    chk(mode_ok, 1'b1);
    @(posedge clk);
    straps <= 3'h2;
    settle;
    chk(mode_o, 3'h5);
  endtask : t_mode

  task automatic t_i2c;
    @(posedge clk);
    i2c_pd <= 2'h3;
    i2c_po <= 2'h2;
    settle;
    chk(i2c_oe, 2'h0);
    chk({sda_in, scl_in, i2c_pi}, 4'he);
    chk(i2c_out, 2'h2);
    @(posedge clk);
    i2c_en <= 1'b1;
    settle;
    chk({i2c_oe, i2c_out}, 4'hc);
    chk({sda_in, scl_in}, 2'h3);
    @(posedge clk);
    sda_low  <= 1'b1;
    pull_low <= 2'h1;
    settle;
    chk({i2c_oe, i2c_out.port_h_bit6}, 3'h2);
    chk({sda_in, scl_in}, 2'h0);
    @(posedge clk);
    sda_low  <= 1'b0;
    scl_low  <= 1'b1;
    pull_low <= 2'h0;
    settle;
    chk({i2c_oe, sda_in, scl_in}, 4'ha);
    @(posedge clk);
    {i2c_en, sda_low, scl_low, pull_low, i2c_po, i2c_pd} <= '0;
  endtask : t_i2c

  task automatic t_chan(input int g);
    @(posedge clk);
    cfg[g]         <= 4'hc;
    ack[g]         <= 1'b1;
    eop[g]         <= 1'b1;
    ch_pd[g]       <= 3'h3;
    drv_en[3*g+2]  <= 1'b1;
    drv_val[3*g+2] <= 1'b1;
    settle;
    chk(ch_oe[g], 3'h4);
    chk(ch_out[g].ack, 1'b1);
    chk(req_o, 3'h1 << g);
    chk(stop_o, 3'h0);
    @(posedge clk);
    cfg[g] <= 4'h2;
    settle;
    chk(ch_oe[g], 3'h4);
    chk({ch_out[g].ack, ch_out[g].end_stop}, 2'h1);
    chk(req_o, 3'h0);
    @(posedge clk);
    cfg[g]       <= 4'h1;
    drv_en[3*g]  <= 1'b1;
    drv_val[3*g] <= 1'b1;
    settle;
    chk(ch_oe[g], 3'h5);
    chk(stop_o, 3'h1 << g);
    @(posedge clk);
    cfg[g]   <= 4'h0;
    ch_po[g] <= 3'h1;
    drv_en   <= '0;
    settle;
    chk({ch_oe[g], ch_out[g].end_stop, ch_pi[g].end_stop}, 5'h13);
    chk(stop_o, 3'h0);
    @(posedge clk);
    {ch_po[g], ch_pd[g], ack[g], eop[g]} <= '0;
  endtask : t_chan

  // a second reset mid-run: outputs return to reset values, straps are taken again
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    settle;
    chk(ch_oe, 9'h1ff);
    chk({i2c_oe, mode_ok, sda_in, scl_in}, 5'h1b);
    chk(mode_o, 3'h0);
    @(posedge clk);
    rst <= 1'b0;
    settle;
    chk({mode_ok, mode_o}, 4'ha);
  endtask : t_reset

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  initial begin
    {rst, straps} = 4'hd;
    {i2c_en, sda_low, scl_low, pull_low, ack, eop, drv_en, drv_val} = '0;
    {cfg, i2c_po, i2c_pd, ch_po, ch_pd} = '0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(mode_ok, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    settle;
    t_mode;
    t_i2c;
    for (int g = 0; g < 3; g++) begin
      t_chan(g);
    end
    t_reset;
    settle;
    tally_and_finish;
  end
endmodule : tb_pmx_pin_mux
